// ==== design/sbt_tap.sv ====
// Boundary-scan test access port of the memory device
// Notes on behaviour
// - Inputs sampled at test-clock rise, serial output updated at test-clock fall.
// - Mode select steers the state machine; unconnected reads as high.
// - Serial data enters at MSB, leaves from LSB of selected register.
// - Serial output driven only in shift states, floating otherwise.
// - Five rising edges with mode select high reset the port.
// - Power-up resets the port internally; serial output floats.
// - The current instruction selects exactly one serial register.
// - Instruction register is three bits, loaded serially in shift-IR.
// - Identification instruction loaded at power-up and test-logic reset.
// - Capture-IR loads binary 01 into the two low bits.
// - One-bit bypass register, single stage, cleared under bypass.
// - Capture-DR loads all pin cells; they shift in shift-DR.
// - Identification instruction captures a fixed 32-bit value for shifting.
// - Shifted instruction takes effect only at Update-IR.
// - Capture-and-float selects boundary register and floats memory outputs.
// - Sample/preload snapshots pin states without disturbing memory.
// - Preload places shifted pattern into latched cell outputs.
// - Captured data shifts out while new preload data shifts in.
// - Codes: 000 extest, 001 id, 010 float, 100 sample, 111 bypass, others reserved.
// - Bypass instruction places the bypass bit in the serial path.
// - Extest drives preloaded values onto pins, boundary register in path.
// - Cell 47 enables outputs under extest; presets high at reset.
`timescale 1ns/1ps
`default_nettype none
module sbt_tap (
  // Clock and reset
  input  wire  logic                         clk_sys_i,
  input  wire  logic                         reset_i,
  // Test-port pins (asynchronous to clk_sys_i)
  input  wire  sbt_pkg::sbt_pins_type        pins_i,
  output var   sbt_pkg::sbt_tdo_type         tdo_o,
  // Memory pin ring
  input  wire  logic [sbt_pkg::BSR_WIDTH-1:0] ring_i,
  output logic       [sbt_pkg::BSR_WIDTH-1:0] ring_drive_o,
  output logic                               extest_o,
  output logic                               out_bus_en_o
);

  // ==========================================================
  // Pin synchronisers
  logic [sbt_pkg::SYNC_STAGES-1:0] tck_sync_q;
  logic [sbt_pkg::SYNC_STAGES-1:0] tms_sync_q;
  logic [sbt_pkg::SYNC_STAGES-1:0] tdi_sync_q;
  logic                            tck_last_q;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      tck_sync_q <= '0;
      tms_sync_q <= '1;
      tdi_sync_q <= '1;
      tck_last_q <= 1'b0;
    end else begin
      tck_sync_q <= {tck_sync_q[0], pins_i.tck};
      tms_sync_q <= {tms_sync_q[0], pins_i.tms};
      tdi_sync_q <= {tdi_sync_q[0], pins_i.tdi};
      tck_last_q <= tck_sync_q[1];
    end
  end

  wire tck_rise = tck_sync_q[1] & ~tck_last_q;
  wire tck_fall = ~tck_sync_q[1] & tck_last_q;
  wire tms      = tms_sync_q[1];
  wire tdi      = tdi_sync_q[1];

  // Memory ring runs on another clock; capture reads only the second stage
  logic [sbt_pkg::BSR_WIDTH-1:0] ring_meta_q;
  logic [sbt_pkg::BSR_WIDTH-1:0] ring_sync_q;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ring_meta_q <= '0;
      ring_sync_q <= '0;
    end else begin
      ring_meta_q <= ring_i;
      ring_sync_q <= ring_meta_q;
    end
  end

  // ==========================================================
  // State machine
  sbt_pkg::sbt_state_type state_q;
  sbt_pkg::sbt_state_type state_d;
  sbt_pkg::sbt_state_type next_st;

  always_comb begin
    next_st = sbt_pkg::ST_RESET;
    case (state_q)
      sbt_pkg::ST_RESET:  next_st = tms ? sbt_pkg::ST_RESET  : sbt_pkg::ST_IDLE;
      sbt_pkg::ST_IDLE:   next_st = tms ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
      sbt_pkg::ST_SEL_DR: next_st = tms ? sbt_pkg::ST_SEL_IR : sbt_pkg::ST_CAP_DR;
      sbt_pkg::ST_CAP_DR: next_st = tms ? sbt_pkg::ST_EX1_DR : sbt_pkg::ST_SH_DR;
      sbt_pkg::ST_SH_DR:  next_st = tms ? sbt_pkg::ST_EX1_DR : sbt_pkg::ST_SH_DR;
      sbt_pkg::ST_EX1_DR: next_st = tms ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_PA_DR;
      sbt_pkg::ST_PA_DR:  next_st = tms ? sbt_pkg::ST_EX2_DR : sbt_pkg::ST_PA_DR;
      sbt_pkg::ST_EX2_DR: next_st = tms ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_SH_DR;
      sbt_pkg::ST_UPD_DR: next_st = tms ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
      // Five ones from any state end in reset by this structure
      sbt_pkg::ST_SEL_IR: next_st = tms ? sbt_pkg::ST_RESET  : sbt_pkg::ST_CAP_IR;
      sbt_pkg::ST_CAP_IR: next_st = tms ? sbt_pkg::ST_EX1_IR : sbt_pkg::ST_SH_IR;
      sbt_pkg::ST_SH_IR:  next_st = tms ? sbt_pkg::ST_EX1_IR : sbt_pkg::ST_SH_IR;
      sbt_pkg::ST_EX1_IR: next_st = tms ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_PA_IR;
      sbt_pkg::ST_PA_IR:  next_st = tms ? sbt_pkg::ST_EX2_IR : sbt_pkg::ST_PA_IR;
      sbt_pkg::ST_EX2_IR: next_st = tms ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_SH_IR;
      sbt_pkg::ST_UPD_IR: next_st = tms ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
      default:            next_st = sbt_pkg::ST_RESET;
    endcase
  end

  assign state_d = tck_rise ? next_st : state_q;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= sbt_pkg::ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Capture, shift and update act on the rising test-clock edge in the named state; reset acts throughout Reset
  wire in_reset = state_q == sbt_pkg::ST_RESET;
  wire cap_dr   = tck_rise & (state_q == sbt_pkg::ST_CAP_DR);
  wire sh_dr    = tck_rise & (state_q == sbt_pkg::ST_SH_DR);
  wire upd_dr   = tck_rise & (state_q == sbt_pkg::ST_UPD_DR);
  wire cap_ir   = tck_rise & (state_q == sbt_pkg::ST_CAP_IR);
  wire sh_ir    = tck_rise & (state_q == sbt_pkg::ST_SH_IR);
  wire upd_ir   = tck_rise & (state_q == sbt_pkg::ST_UPD_IR);

  // ==========================================================
  // Instruction register: shift stage and current instruction
  logic [sbt_pkg::IR_WIDTH-1:0] ir_shift_q;
  logic [sbt_pkg::IR_WIDTH-1:0] ir_shift_d;
  logic [sbt_pkg::IR_WIDTH-1:0] ir_q;
  logic [sbt_pkg::IR_WIDTH-1:0] ir_d;

  assign ir_shift_d = cap_ir ? {ir_shift_q[sbt_pkg::IR_WIDTH-1], sbt_pkg::IR_CAPTURE} :
                      sh_ir  ? {tdi, ir_shift_q[sbt_pkg::IR_WIDTH-1:1]} :
                               ir_shift_q;
  assign ir_d = in_reset ? sbt_pkg::INSTR_IDCODE :
                upd_ir   ? ir_shift_q :
                           ir_q;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ir_shift_q <= '0;
      ir_q       <= sbt_pkg::INSTR_IDCODE;
    end else begin
      ir_shift_q <= ir_shift_d;
      ir_q       <= ir_d;
    end
  end

  // ==========================================================
  // Instruction decode; reserved codes behave as bypass as a safe default
  wire sel_extest  = ir_q == sbt_pkg::INSTR_EXTEST;
  wire sel_idcode  = ir_q == sbt_pkg::INSTR_IDCODE;
  wire sel_samplez = ir_q == sbt_pkg::INSTR_SAMPLEZ;
  wire sel_sample  = ir_q == sbt_pkg::INSTR_SAMPLE;
  wire sel_bsr     = sel_extest | sel_samplez | sel_sample;
  wire sel_bypass  = ~sel_bsr & ~sel_idcode;

  // ==========================================================
  // Bypass and identification registers
  logic                         byp_q;
  logic                         byp_d;
  logic [sbt_pkg::ID_WIDTH-1:0] id_q;
  logic [sbt_pkg::ID_WIDTH-1:0] id_d;

  assign byp_d = (cap_dr & sel_bypass) ? 1'b0 :
                 (sh_dr & sel_bypass)  ? tdi : byp_q;
  assign id_d  = (cap_dr & sel_idcode) ? sbt_pkg::ID_VALUE :
                 (sh_dr & sel_idcode)  ? {tdi, id_q[sbt_pkg::ID_WIDTH-1:1]} : id_q;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      byp_q <= 1'b0;
      id_q  <= '0;
    end else begin
      byp_q <= byp_d;
      id_q  <= id_d;
    end
  end

  // ==========================================================
  // Boundary-scan chain; capture, then shift-out and shift-in overlap
  logic [sbt_pkg::BSR_WIDTH-1:0] bsr_shift;
  logic [sbt_pkg::BSR_WIDTH-1:0] bsr_latch;

  sbt_bsr_cells u_cells (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .capture_i   (cap_dr & sel_bsr),
    .shift_i     (sh_dr & sel_bsr),
    .update_i    (upd_dr & sel_bsr),
    .tap_reset_i (in_reset),
    .tdi_i       (tdi),
    .pins_i      (ring_sync_q),
    .shift_o     (bsr_shift),
    .latch_o     (bsr_latch)
  );

  // ==========================================================
  // Serial output, changed on the falling test-clock edge
  wire in_shift = (state_q == sbt_pkg::ST_SH_DR) | (state_q == sbt_pkg::ST_SH_IR);
  wire tdo_mux  = (state_q == sbt_pkg::ST_SH_IR) ? ir_shift_q[0] :
                  sel_idcode ? id_q[0] :
                  sel_bsr    ? bsr_shift[0] : byp_q;

  logic tdo_q;
  logic tdo_d;
  logic tdo_oe_q;
  logic tdo_oe_d;
  logic extest_q;
  logic bus_en_q;

  assign tdo_d    = tck_fall ? tdo_mux : tdo_q;
  assign tdo_oe_d = tck_fall ? in_shift : tdo_oe_q;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_q    <= tdo_d;
      tdo_oe_q <= tdo_oe_d;
    end
  end

  // Memory output control; sample/preload leaves memory untouched
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      extest_q <= 1'b0;
      bus_en_q <= 1'b1;
    end else begin
      extest_q <= sel_extest;
      bus_en_q <= ~sel_samplez & (~sel_extest | bsr_latch[sbt_pkg::BSR_OE_BIT]);
    end
  end

  assign tdo_o.tdo    = tdo_q;
  assign tdo_o.tdo_oe = tdo_oe_q;
  assign ring_drive_o = bsr_latch;
  assign extest_o     = extest_q;
  assign out_bus_en_o = bus_en_q;

endmodule
`default_nettype wire

// ==== design/sbt_pkg.sv ====
// Package: constants and types for the memory boundary-scan test port
`default_nettype none
package sbt_pkg;

  localparam int IR_WIDTH     = 3;
  localparam int ID_WIDTH     = 32;
  localparam int BSR_WIDTH    = 107;
  localparam int BSR_OE_BIT   = 47;
  localparam int RESET_ONES   = 5;
  localparam int SYNC_STAGES  = 2;

  localparam logic [2:0] INSTR_EXTEST  = 3'h0;
  localparam logic [2:0] INSTR_IDCODE  = 3'h1;
  localparam logic [2:0] INSTR_SAMPLEZ = 3'h2;
  localparam logic [2:0] INSTR_SAMPLE  = 3'h4;
  localparam logic [2:0] INSTR_BYPASS  = 3'h7;
  localparam logic [1:0] IR_CAPTURE    = 2'h1;

  // Identity value is arbitrary; only the presence bit 0 is fixed at one
  localparam logic [31:0] ID_VALUE = 32'h0ABC_D001;

  // Gray-coded along Reset, Idle, Select-DR, Capture-DR, Shift-DR, Exit1, ...
  typedef enum logic [3:0] {
    ST_RESET   = 4'h0,
    ST_IDLE    = 4'h1,
    ST_SEL_DR  = 4'h3,
    ST_CAP_DR  = 4'h2,
    ST_SH_DR   = 4'h6,
    ST_EX1_DR  = 4'h7,
    ST_PA_DR   = 4'h5,
    ST_EX2_DR  = 4'h4,
    ST_UPD_DR  = 4'hC,
    ST_SEL_IR  = 4'hD,
    ST_CAP_IR  = 4'hF,
    ST_SH_IR   = 4'hE,
    ST_EX1_IR  = 4'hA,
    ST_PA_IR   = 4'hB,
    ST_EX2_IR  = 4'h9,
    ST_UPD_IR  = 4'h8
  } sbt_state_type;

  // Serial test-port pins as seen by the block
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sbt_pins_type;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } sbt_tdo_type;

endpackage
`default_nettype wire

// ==== design/sbt_bsr_cells.sv ====
// Boundary-scan cell chain: shift stage and latched parallel update stage
`timescale 1ns/1ps
`default_nettype none
module sbt_bsr_cells (
  // Clock and reset
  input  wire  logic                         clk_sys_i,
  input  wire  logic                         reset_i,
  // Control from the test-port controller
  input  wire  logic                         capture_i,
  input  wire  logic                         shift_i,
  input  wire  logic                         update_i,
  input  wire  logic                         tap_reset_i,
  input  wire  logic                         tdi_i,
  // Parallel pin values and outputs
  input  wire  logic [sbt_pkg::BSR_WIDTH-1:0] pins_i,
  output logic       [sbt_pkg::BSR_WIDTH-1:0] shift_o,
  output logic       [sbt_pkg::BSR_WIDTH-1:0] latch_o
);

  // ==========================================================
  // Reset pattern of the latched outputs
  localparam logic [sbt_pkg::BSR_WIDTH-1:0] LATCH_INIT =
    {{(sbt_pkg::BSR_WIDTH-1){1'b0}}, 1'b1} << sbt_pkg::BSR_OE_BIT;

  logic [sbt_pkg::BSR_WIDTH-1:0] shift_q;
  logic [sbt_pkg::BSR_WIDTH-1:0] shift_d;
  logic [sbt_pkg::BSR_WIDTH-1:0] latch_q;
  logic [sbt_pkg::BSR_WIDTH-1:0] latch_d;

  // ==========================================================
  // Shift stage
  assign shift_d = capture_i ? pins_i :
                   shift_i   ? {tdi_i, shift_q[sbt_pkg::BSR_WIDTH-1:1]} :
                               shift_q;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      shift_q <= '0;
    end else begin
      shift_q <= shift_d;
    end
  end

  // ==========================================================
  // Update stage; the output-enable cell presets high
  assign latch_d = tap_reset_i ? LATCH_INIT :
                   update_i    ? shift_q :
                                 latch_q;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      latch_q <= LATCH_INIT;
    end else begin
      latch_q <= latch_d;
    end
  end

  assign shift_o = shift_q;
  assign latch_o = latch_q;

endmodule
`default_nettype wire

// ==== verif/sbt_tap_checker.sv ====
// Checker: port-level assertions for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module sbt_tap_checker (
  // Clock and reset
  input wire logic                          clk_sys_i,
  input wire logic                          reset_i,
  // Watched ports
  input wire sbt_pkg::sbt_pins_type         pins_i,
  input wire sbt_pkg::sbt_tdo_type          tdo_o,
  input wire logic [sbt_pkg::BSR_WIDTH-1:0] ring_i,
  input wire logic [sbt_pkg::BSR_WIDTH-1:0] ring_drive_o,
  input wire logic                          extest_o,
  input wire logic                          out_bus_en_o
);
  localparam logic [sbt_pkg::BSR_WIDTH-1:0] RST_PAT =
    {{(sbt_pkg::BSR_WIDTH-1){1'b0}}, 1'b1} << sbt_pkg::BSR_OE_BIT;
  logic [2:0] tck_q;
  logic [1:0] tms_q;
  logic       tms_at_rise_q;
  logic [3:0] since_rise_q;
  logic [3:0] since_fall_q;
  logic [2:0] ones_q;
  wire  logic rise = tck_q[1] & ~tck_q[2];
  wire  logic fall = ~tck_q[1] & tck_q[2];
  // ========================================
  // Test-clock edge tracking, same synchroniser depth as the block
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      tck_q <= 3'h0;
      tms_q <= 2'h3;
      tms_at_rise_q <= 1'b1;
      since_rise_q <= 4'hF;
      since_fall_q <= 4'hF;
      ones_q <= 3'h0;
    end else begin
      tck_q <= {tck_q[1:0], pins_i.tck};
      tms_q <= {tms_q[0], pins_i.tms};
      tms_at_rise_q <= rise ? tms_q[1] : tms_at_rise_q;
      since_rise_q <= rise ? 4'h0 : (since_rise_q == 4'hF ? 4'hF : since_rise_q + 4'h1);
      since_fall_q <= fall ? 4'h0 : (since_fall_q == 4'hF ? 4'hF : since_fall_q + 4'h1);
      ones_q <= !rise ? ones_q : (!tms_q[1] ? 3'h0 : (ones_q == 3'h5 ? 3'h5 : ones_q + 3'h1));
    end
  end
  // ========================================
  // Assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  power_up_state_a: assert property ($fell(reset_i) |-> !tdo_o.tdo_oe && !extest_o
    && out_bus_en_o && ring_drive_o == RST_PAT) else $error("bad state after reset");
  tdo_on_fall_a: assert property ($changed(tdo_o) |-> since_fall_q <= 4'h3)
    else $error("serial output moved away from a test-clock fall");
  oe_enter_shift_a: assert property ($rose(tdo_o.tdo_oe) |-> !tms_at_rise_q)
    else $error("output enabled outside a shift state");
  oe_leave_shift_a: assert property ($fell(tdo_o.tdo_oe) |-> tms_at_rise_q)
    else $error("output released while still shifting");
  five_ones_a: assert property (ones_q == 3'h5 |-> ##[0:4] (!extest_o
    && ring_drive_o == RST_PAT)) else $error("five high mode bits did not reset");
  oe_cell_a: assert property (extest_o && $past(extest_o) && $stable(ring_drive_o)
    |-> out_bus_en_o == ring_drive_o[sbt_pkg::BSR_OE_BIT]) else $error("bus enable cell ignored");
  latch_on_rise_a: assert property ($changed(ring_drive_o) |-> since_rise_q <= 4'h3)
    else $error("latched cells moved away from a test-clock rise");
  instr_on_rise_a: assert property ($changed({extest_o, out_bus_en_o})
    |-> since_rise_q <= 4'h3) else $error("instruction outputs moved off a rise");
  cover property (extest_o && !out_bus_en_o);
  cover property (!extest_o && !out_bus_en_o);
  cover property ($rose(tdo_o.tdo_oe));
endmodule
bind sbt_tap sbt_tap_checker u_chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .pins_i(pins_i),
  .tdo_o(tdo_o), .ring_i(ring_i), .ring_drive_o(ring_drive_o), .extest_o(extest_o),
  .out_bus_en_o(out_bus_en_o));
`default_nettype wire

// ==== verif/sbt_tester.sv ====
// Partner model: external tester that drives the serial test pins
`timescale 1ns/1ps
`default_nettype none
module sbt_tester (
  // Pacing clock
  input  wire logic                  clk_sys_i,
  // Serial test pins
  output var  sbt_pkg::sbt_pins_type pins_o,
  input  wire sbt_pkg::sbt_tdo_type  tdo_i
);
  // 200 ns each half gives 2.5 MHz, well under the ceiling
  localparam int HALF = 4;
  // Unconnected serial output floats when the device releases it
  wire logic tdo_wire = tdo_i.tdo_oe ? tdo_i.tdo : 1'bz;
  // Test clock parked low; mode select and data rest at their pull-up level
  initial pins_o = 3'h3;
  task automatic clock_bit(input logic tms, input logic tdi, output logic tdo);
    pins_o.tms = tms;
    pins_o.tdi = tdi;
    repeat (HALF) @(negedge clk_sys_i);
    pins_o.tck = 1'b1;
    repeat (HALF) @(negedge clk_sys_i);
    tdo = tdo_wire;
    pins_o.tck = 1'b0;
  endtask
  // ========================================
  // Full scan from Idle back to Idle, LSB of din first
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic b;
    dout = 128'h0;
    clock_bit(1'b1, 1'b1, b);
    if (ir) begin
      clock_bit(1'b1, 1'b1, b);
    end
    clock_bit(1'b0, 1'b1, b);
    clock_bit(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      clock_bit(i == n - 1, din[i], b);
      dout[i] = b;
    end
    clock_bit(1'b1, 1'b1, b);
    clock_bit(1'b0, 1'b1, b);
  endtask
  task automatic tap_reset();
    logic b;
    repeat (5) clock_bit(1'b1, 1'b1, b);
    clock_bit(1'b0, 1'b1, b);
  endtask
endmodule
`default_nettype wire

// ==== verif/sbt_tap_tb.sv ====
// Testbench: drives the test port through the tester model and checks results
`timescale 1ns/1ps
`default_nettype none
module sbt_tap_tb;
  localparam int W = sbt_pkg::BSR_WIDTH;
  localparam logic [W-1:0] RING_PAT = 107'h5_3C96_A5F0_0FF1_2345_6789_ABCD;
  localparam logic [W-1:0] PRE_PAT  = 107'h3_0F0F_FFFF_0000_43C3_5A5A_1234;
  localparam logic [W-1:0] RST_PAT  = {{(W-1){1'b0}}, 1'b1} << sbt_pkg::BSR_OE_BIT;
  logic                  clk_sys_i;
  logic                  reset_i;
  sbt_pkg::sbt_pins_type pins;
  sbt_pkg::sbt_tdo_type  tdo;
  logic [W-1:0]          ring_i;
  logic [W-1:0]          ring_drive_o;
  logic                  extest_o;
  logic                  out_bus_en_o;
  int                    fails;
  int                    compares;
  int                    cycles;
  sbt_tap dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .pins_i(pins), .tdo_o(tdo),
    .ring_i(ring_i), .ring_drive_o(ring_drive_o), .extest_o(extest_o),
    .out_bus_en_o(out_bus_en_o));
  sbt_tester u_tester (.clk_sys_i(clk_sys_i), .pins_o(pins), .tdo_i(tdo));
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // ========================================
  // Shared tasks
  task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Only defined codes are ever shifted in
  task automatic load_ir(input logic [2:0] code);
    logic [127:0] d;
    u_tester.scan(1'b1, sbt_pkg::IR_WIDTH, {125'h0, code}, d);
    check("ir capture", 128'h1, {126'h0, d[1:0]});
  endtask
  task automatic pins_state(input logic ext, input logic en, input logic [W-1:0] drv);
    check("extest", {127'h0, ext}, {127'h0, extest_o});
    check("bus enable", {127'h0, en}, {127'h0, out_bus_en_o});
    check("latched cells", {21'h0, drv}, {21'h0, ring_drive_o});
    check("output enable idle", 128'h0, {127'h0, tdo.tdo_oe});
  endtask
  // ========================================
  // Scenarios
  task automatic test_idcode();
    logic [127:0] d;
    u_tester.tap_reset();
    u_tester.scan(1'b0, sbt_pkg::ID_WIDTH, 128'h0, d);
    check("id value", {96'h0, sbt_pkg::ID_VALUE}, d);
  endtask
  task automatic test_bypass();
    logic [127:0] d;
    load_ir(sbt_pkg::INSTR_BYPASS);
    u_tester.scan(1'b0, 4, 128'hD, d);
    check("bypass path", 128'hA, d);
  endtask
  task automatic test_sample_preload();
    logic [127:0] d;
    load_ir(sbt_pkg::INSTR_SAMPLE);
    u_tester.scan(1'b0, W, {21'h0, PRE_PAT}, d);
    check("sample capture", {21'h0, RING_PAT}, d);
    pins_state(1'b0, 1'b1, PRE_PAT);
  endtask
  task automatic test_extest();
    logic [127:0] d;
    load_ir(sbt_pkg::INSTR_EXTEST);
    pins_state(1'b1, PRE_PAT[sbt_pkg::BSR_OE_BIT], PRE_PAT);
    // A fresh ring pattern proves capture samples the pins at Capture-DR
    ring_i = ~RING_PAT;
    u_tester.scan(1'b0, W, {21'h0, ~PRE_PAT}, d);
    check("extest capture", {21'h0, ~RING_PAT}, d);
    pins_state(1'b1, ~PRE_PAT[sbt_pkg::BSR_OE_BIT], ~PRE_PAT);
  endtask
  task automatic test_float_then_reset();
    logic [127:0] d;
    load_ir(sbt_pkg::INSTR_SAMPLEZ);
    pins_state(1'b0, 1'b0, ~PRE_PAT);
    u_tester.scan(1'b0, W, 128'h0, d);
    check("float capture", {21'h0, ~RING_PAT}, d);
    u_tester.tap_reset();
    pins_state(1'b0, 1'b1, RST_PAT);
    test_idcode();
  endtask
  // ========================================
  // Hang guard: the whole sequence needs about 3800 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    reset_i = 1'b1;
    ring_i = RING_PAT;
    repeat (12) @(negedge clk_sys_i);
    reset_i = 1'b0;
    @(negedge clk_sys_i);
    pins_state(1'b0, 1'b1, RST_PAT);
    test_idcode();
    test_bypass();
    test_sample_preload();
    test_extest();
    test_float_then_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
